// ### logic/ldpc_ctrl.sv
// Power-down and wake control for the on-chip regulators, analog reset and reference.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/10ps
`include "ldpc_map.svh"
module ldpc_ctrl
#(
  parameter bit USB_REG_PRESENT = 1'b1
)
(
  input  wire logic              CORE_CLK,
  input  wire logic              RST_N,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [31:0]       PADDR,
  input  wire ldpc_pkg::ldpc_word_t PWDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  output ldpc_pkg::ldpc_word_t   PRDATA,
  input  wire logic              WAKE_PIN_IN,
  output logic                   WAKE_PIN_OUT,
  output logic                   WAKE_PIN_OE,
  input  wire logic              RTC_ALARM,
  input  wire logic              RTC_CLK_IN_LEVEL,
  output logic                   CLOCK_OUT,
  output logic                   ANALOG_REGULATOR_ON,
  output logic                   USB_REGULATOR_ON,
  output logic                   ANALOG_POR_ON,
  output logic                   REFERENCE_ON,
  output logic                   WAKE_EVENT
);
  import ldpc_pkg::*;

  typedef struct packed {
    ldpc_state_e state;
    logic        clock_out_enable;
    logic        regulator_shutdown;
    logic        reference_shutdown;
    logic        wake_pin_direction;
    logic        wake_pin_output_value;
    logic        usb_regulator_enable;
    logic        clk_meta;
    logic        clk_sync;
    logic        pready;
    logic        pslverr;
    ldpc_word_t  prdata;
    logic        wake_out;
    logic        wake_oe;
    logic        clock_out;
    logic        ana_on;
    logic        usb_on;
    logic        por_on;
    logic        ref_on;
    logic        wake_event;
  } ldpc_ctrl_s;

  ldpc_ctrl_s st_q;
  ldpc_ctrl_s st_d;

  ldpc_sync_if sync_if ();

  logic wake_pin_s;
  logic alarm_s;
  logic setup;
  logic access;
  logic hit_pmgt;
  logic hit_ctrl;
  logic hit_stat;
  logic pin_wake;
  logic wake_req;
  logic [15:0] addr16;

  initial
  begin
    if (`LDPC_MIN_WAKE_CYCLES < 1)
    begin
      $error("Wake latency must be at least one cycle.");
    end
  end

  assign sync_if.raw = {RTC_ALARM, WAKE_PIN_IN};
  assign wake_pin_s  = sync_if.clean[0];
  assign alarm_s     = sync_if.clean[1];

  ldpc_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk     (CORE_CLK),
    .rst_n   (RST_N),
    .port_if (sync_if.sync)
  );

  assign addr16   = PADDR[15:0];
  assign setup    = PSEL && !PENABLE;
  assign access   = PSEL && PENABLE && st_q.pready;
  assign hit_pmgt = (PADDR[31:16] == 16'h0000) && (addr16 == `LDPC_RTC_PMGT_OFF);
  assign hit_ctrl = (PADDR[31:16] == 16'h0000) && (addr16 == `LDPC_REG_CTRL_OFF);
  assign hit_stat = (PADDR[31:16] == 16'h0000) && (addr16 == `LDPC_STATUS_OFF);

  // A high input level wakes only in input direction; an output never self-wakes.
  assign pin_wake = !st_q.wake_pin_direction && wake_pin_s;
  assign wake_req = pin_wake || alarm_s;

  always_comb
  begin
    st_d            = st_q;
    st_d.wake_event = 1'b0;
    st_d.clk_meta   = RTC_CLK_IN_LEVEL;
    st_d.clk_sync   = st_q.clk_meta;
    // Slave answers one cycle after setup, so no access has a wait state.
    st_d.pready     = setup;
    if (setup)
    begin
      st_d.pslverr = !(hit_pmgt || hit_ctrl || hit_stat);
      st_d.prdata  = 32'h0000_0000;
      if (hit_pmgt)
      begin
        st_d.prdata[`LDPC_PMGT_CLKOUT_BIT] = st_q.clock_out_enable;
        st_d.prdata[`LDPC_PMGT_REGSD_BIT]  = st_q.regulator_shutdown;
        st_d.prdata[`LDPC_PMGT_REFSD_BIT]  = st_q.reference_shutdown;
        st_d.prdata[`LDPC_PMGT_WDIR_BIT]   = st_q.wake_pin_direction;
        st_d.prdata[`LDPC_PMGT_WOUT_BIT]   = st_q.wake_pin_output_value;
      end
      else if (hit_ctrl)
      begin
        st_d.prdata[0] = st_q.usb_regulator_enable;
      end
      else if (hit_stat)
      begin
        st_d.prdata[2:0] = st_q.state;
        st_d.prdata[3]   = st_q.ana_on;
        st_d.prdata[4]   = st_q.usb_on;
        st_d.prdata[5]   = st_q.ref_on;
        st_d.prdata[6]   = wake_pin_s;
      end
    end
    else if (access)
    begin
      st_d.pslverr = 1'b0;
    end

    if (access && PWRITE && hit_pmgt)
    begin
      st_d.clock_out_enable      = PWDATA[`LDPC_PMGT_CLKOUT_BIT];
      st_d.regulator_shutdown    = PWDATA[`LDPC_PMGT_REGSD_BIT];
      st_d.reference_shutdown    = PWDATA[`LDPC_PMGT_REFSD_BIT];
      st_d.wake_pin_direction    = PWDATA[`LDPC_PMGT_WDIR_BIT];
      st_d.wake_pin_output_value = PWDATA[`LDPC_PMGT_WOUT_BIT];
    end
    if (access && PWRITE && hit_ctrl)
    begin
      // Upper bits are dropped; on a part without the regulator the bit stays 0.
      st_d.usb_regulator_enable = PWDATA[0] && USB_REG_PRESENT;
    end

    unique case (st_q.state)
      LDPC_RUN:
      begin
        if (st_d.regulator_shutdown || st_d.reference_shutdown)
        begin
          st_d.state = LDPC_DOWN;
        end
      end
      LDPC_DOWN:
      begin
        // Wake has priority over a shutdown still held in the register.
        if (wake_req)
        begin
          st_d.state              = LDPC_WAKE;
          st_d.regulator_shutdown = 1'b0;
          st_d.reference_shutdown = 1'b0;
          st_d.wake_event         = 1'b1;
        end
      end
      LDPC_WAKE:
      begin
        if (!wake_req)
        begin
          st_d.state = LDPC_RUN;
        end
      end
      default:
      begin
        st_d.state = LDPC_RUN;
      end
    endcase

    st_d.ref_on = !(st_d.state == LDPC_DOWN && st_d.reference_shutdown);
    st_d.ana_on = (st_d.state != LDPC_DOWN);
    st_d.por_on = (st_d.state != LDPC_DOWN);
    st_d.usb_on = (st_d.state != LDPC_DOWN) && st_d.usb_regulator_enable;
    st_d.clock_out = st_q.clock_out_enable && st_q.clk_sync;
    // Open drain: drive low only when output direction and value 0.
    st_d.wake_oe  = st_d.wake_pin_direction && !st_d.wake_pin_output_value;
    st_d.wake_out = 1'b0;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      st_q                       <= '0;
      st_q.state                 <= LDPC_RUN;
      st_q.wake_pin_output_value <= 1'b1;
      st_q.usb_regulator_enable  <= `LDPC_REG_CTRL_RESET;
      st_q.ana_on                <= 1'b1;
      st_q.por_on                <= 1'b1;
      st_q.ref_on                <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign PREADY              = st_q.pready;
  assign PSLVERR             = st_q.pslverr;
  assign PRDATA              = st_q.prdata;
  assign WAKE_PIN_OUT        = st_q.wake_out;
  assign WAKE_PIN_OE         = st_q.wake_oe;
  assign CLOCK_OUT           = st_q.clock_out;
  assign ANALOG_REGULATOR_ON = st_q.ana_on;
  assign USB_REGULATOR_ON    = st_q.usb_on;
  assign ANALOG_POR_ON       = st_q.por_on;
  assign REFERENCE_ON        = st_q.ref_on;
  assign WAKE_EVENT          = st_q.wake_event;
endmodule

// ### logic/ldpc_map.svh
// Register offsets, field positions and reset values of the power-down control block.
`ifndef LDPC_MAP_SVH
`define LDPC_MAP_SVH
`define LDPC_RTC_PMGT_OFF     16'h1930
`define LDPC_REG_CTRL_OFF     16'h7004
`define LDPC_STATUS_OFF       16'h7008
`define LDPC_PMGT_CLKOUT_BIT  0
`define LDPC_PMGT_REGSD_BIT   1
`define LDPC_PMGT_REFSD_BIT   2
`define LDPC_PMGT_WDIR_BIT    3
`define LDPC_PMGT_WOUT_BIT    4
`define LDPC_PMGT_RESET       5'h10
`define LDPC_REG_CTRL_RESET   1'h0
`define LDPC_ADDR_W           16
`define LDPC_MIN_WAKE_CYCLES  1
`endif

// ### logic/ldpc_pkg.sv
// Types shared by the power-down control modules.
package ldpc_pkg;
  typedef enum logic [2:0] {
    LDPC_RUN   = 3'b001,
    LDPC_DOWN  = 3'b010,
    LDPC_WAKE  = 3'b100
  } ldpc_state_e;
  typedef logic [31:0] ldpc_word_t;
endpackage

// ### logic/ldpc_sync_if.sv
// Interface carrying raw pin levels into the synchroniser and the clean levels out.
`timescale 1ns/10ps
interface ldpc_sync_if;
  logic [1:0] raw;
  logic [1:0] clean;
  modport sync (input raw, output clean);
  modport user (output raw, input clean);
endinterface

// ### logic/ldpc_sync.sv
// Two-flop synchroniser for the asynchronous wake inputs.
`timescale 1ns/10ps
module ldpc_sync
#(
  parameter int WIDTH = 2
)
(
  input  wire logic   clk,
  input  wire logic   rst_n,
  ldpc_sync_if.sync   port_if
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } ldpc_sync_s;

  ldpc_sync_s state_q;
  ldpc_sync_s state_d;

  initial
  begin
    if (WIDTH != 2)
    begin
      $error("Synchroniser width must match the interface.");
    end
  end

  always_comb
  begin
    state_d      = state_q;
    state_d.meta = port_if.raw;
    state_d.sync = state_q.meta;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign port_if.clean = state_q.sync;
endmodule

// ### tb/ldpc_ctrl_asserts.sv
// Port checker for the power-down control block.
`timescale 1ns/10ps
module ldpc_ctrl_asserts
(
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic PREADY,
  input wire logic WAKE_PIN_OUT,
  input wire logic RTC_CLK_IN_LEVEL,
  input wire logic CLOCK_OUT,
  input wire logic ANALOG_REGULATOR_ON,
  input wire logic USB_REGULATOR_ON,
  input wire logic ANALOG_POR_ON,
  input wire logic REFERENCE_ON,
  input wire logic WAKE_EVENT
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);
  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_all_on;
    ANALOG_REGULATOR_ON && ANALOG_POR_ON && REFERENCE_ON;
  endsequence
  a_ready_next: assert property (s_setup |=> PREADY)
    else $error("no ready after setup");
  a_ready_once: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  a_ref_off: assert property (!REFERENCE_ON |-> !ANALOG_REGULATOR_ON)
    else $error("regulator on while reference off");
  a_por_tie: assert property (ANALOG_POR_ON == ANALOG_REGULATOR_ON)
    else $error("analog reset and regulator differ");
  a_usb_gate: assert property (USB_REGULATOR_ON |-> ANALOG_REGULATOR_ON)
    else $error("usb regulator on during shutdown");
  a_pin_low: assert property (!WAKE_PIN_OUT)
    else $error("wake pin driven high");
  a_wake_on: assert property (WAKE_EVENT |-> ##[0:2] s_all_on)
    else $error("wake did not restore power");
  a_wake_pulse: assert property (WAKE_EVENT |=> !WAKE_EVENT)
    else $error("wake event longer than one cycle");
  a_clk_lag: assert property (CLOCK_OUT |-> $past(RTC_CLK_IN_LEVEL, 3))
    else $error("clock out without rtc clock");
  a_off_cause: assert property ($fell(ANALOG_REGULATOR_ON) |->
    $past(PREADY && PWRITE) || $past(PREADY && PWRITE, 2))
    else $error("regulator fell without a write");
endmodule

// ### tb/ldpc_board.sv
// Board model: reset source, wake pin wire with pull-up and RTC clock.
`timescale 1ns/10ps
module ldpc_board
(
  input  wire logic clk,
  input  wire logic wake_req,
  input  wire logic drive,
  input  wire logic rtc_run,
  input  wire logic pin_out,
  input  wire logic pin_oe,
  output logic      rst_n,
  output logic      pin_level,
  output logic      rtc_clk
);
  int cnt = 0;
  initial rtc_clk = 1'b0;
  // Reset stays low until the supplies count as settled.
  always @(posedge clk)
    if (cnt < 12)
      cnt <= cnt + 1;
  assign rst_n = cnt >= 12;
  // The wire is low while pulled down, else the board level or the pull-up.
  assign pin_level = pin_oe ? pin_out : (drive ? wake_req : 1'b1);
  // The RTC clock runs only while asked, out of phase with the core clock.
  always #7 if (rtc_run) rtc_clk = ~rtc_clk;
endmodule

// ### tb/ldo_power_down_control_tb.sv
// Self-checking bench of the power-down control block.
`timescale 1ns/10ps
`include "ldpc_map.svh"
module ldo_power_down_control_tb;
  logic clk = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, alarm = 1'b0;
  logic wreq = 1'b0, drv = 1'b1, run = 1'b0, rst_n, pready, perr, pin_out, pin_oe, pin;
  logic rtc, clk_out, ana, usb, por, ref_on, wev;
  logic [31:0] paddr = '0, pwdata = '0, rd;
  logic err;
  ldpc_pkg::ldpc_word_t prdata;
  int n_mismatch = 0, check_count = 0, hi = 0;
  localparam logic [31:0] PM = `LDPC_RTC_PMGT_OFF;
  localparam logic [31:0] CT = `LDPC_REG_CTRL_OFF;
  always #2 clk = ~clk;
  always @(posedge clk) if (clk_out === 1'b1) hi <= hi + 1;
  ldpc_board board_u (.clk(clk), .wake_req(wreq), .drive(drv), .rtc_run(run),
    .pin_out(pin_out), .pin_oe(pin_oe), .rst_n(rst_n), .pin_level(pin), .rtc_clk(rtc));
  ldpc_ctrl dut_u (.CORE_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PSLVERR(perr), .PRDATA(prdata),
    .WAKE_PIN_IN(pin), .WAKE_PIN_OUT(pin_out), .WAKE_PIN_OE(pin_oe), .RTC_ALARM(alarm),
    .RTC_CLK_IN_LEVEL(rtc), .CLOCK_OUT(clk_out), .ANALOG_REGULATOR_ON(ana),
    .USB_REGULATOR_ON(usb), .ANALOG_POR_ON(por), .REFERENCE_ON(ref_on), .WAKE_EVENT(wev));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && n++ < 20);
    chk("bus ready", 1, pready);
    rd = prdata;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic t_reset();
    apb(0, PM, 0);
    chk("power reg reset", 32'h10, rd);
    apb(0, CT, 0);
    chk("control reg reset", 0, rd);
    chk("usb reset", 0, usb);
    apb(0, 32'h7008, 0);
    chk("status reset", 32'h29, rd);
  endtask
  task automatic t_regs();
    apb(1, CT, 32'hFFFF);
    apb(0, CT, 0);
    chk("control reserved", 1, rd);
    chk("usb on", 1, usb);
    apb(1, 32'h0100, 0);
    chk("unmapped error", 1, err);
    drv <= 1'b0;
    apb(1, PM, 32'hFFE9);
    apb(0, PM, 0);
    chk("power reg", 32'h09, rd);
    chk("pin pulled low", 0, pin);
    run <= 1'b1;
    hi = 0;
    repeat (40) @(posedge clk);
    chk("clock out on", 1, hi > 0);
    apb(1, PM, 32'h18);
    repeat (2) @(posedge clk);
    hi = 0;
    repeat (40) @(posedge clk);
    chk("clock out off", 0, hi);
    chk("pin released", 1, pin);
    run <= 1'b0;
  endtask
  // The board uses the internal regulators, so shutdown is allowed.
  task automatic t_nowake();
    apb(1, PM, 32'h1A);
    repeat (10) @(posedge clk);
    chk("regulator off", 0, ana);
    chk("reference kept", 1, ref_on);
    chk("usb off", 0, usb);
    alarm <= 1'b1;
    repeat (6) @(posedge clk);
    chk("alarm wake", 1, ana);
    alarm <= 1'b0;
    apb(0, PM, 0);
    chk("shutdown cleared", 32'h18, rd);
  endtask
  task automatic t_refsd();
    int n = 0;
    drv <= 1'b1;
    apb(1, PM, 32'h14);
    repeat (4) @(posedge clk);
    chk("reference off", 0, ref_on);
    chk("analog reset off", 0, por);
    wreq <= 1'b1;
    while (wev !== 1'b1 && n++ < 10) @(posedge clk);
    chk("wake event", 1, wev);
    wreq <= 1'b0;
    repeat (3) @(posedge clk);
    chk("usb back", 1, usb);
    apb(1, PM, 32'h10);
    repeat (4) @(posedge clk);
    chk("stays on", 1, ana & ref_on);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #20000;
    n_mismatch++;
    print_verdict();
  end
  initial
  begin
    wait (rst_n === 1'b1);
    t_reset();
    t_regs();
    t_nowake();
    t_refsd();
    print_verdict();
  end
endmodule
bind ldpc_ctrl ldpc_ctrl_asserts chk_u (.CORE_CLK, .RST_N, .PSEL, .PENABLE, .PWRITE,
  .PREADY, .WAKE_PIN_OUT, .RTC_CLK_IN_LEVEL, .CLOCK_OUT, .ANALOG_REGULATOR_ON,
  .USB_REGULATOR_ON, .ANALOG_POR_ON, .REFERENCE_ON, .WAKE_EVENT);
